// *** logic/pfr_pkg.sv ***
package pfr_pkg;

    // flag register width and bit positions
    localparam int FLAG_W   = 8;
    localparam int BIT_EE   = 7;
    localparam int BIT_CONV = 6;
    localparam int BIT_RX   = 5;
    localparam int BIT_TX   = 4;
    localparam int BIT_SSP  = 3;
    localparam int BIT_CCP  = 2;
    localparam int BIT_T2   = 1;
    localparam int BIT_T1   = 0;

    typedef logic [FLAG_W-1:0] pfr_flags_t;

    // byte addresses on the register bus
    localparam logic [7:0] FLAGS_OFS = 8'h0C;
    localparam logic [7:0] MASK_OFS  = 8'h10;
    localparam logic [7:0] PEND_OFS  = 8'h14;

    // reset values
    localparam pfr_flags_t FLAGS_RST = 8'h00;
    localparam pfr_flags_t MASK_RST  = 8'h00;
    localparam pfr_flags_t PEND_RST  = 8'h00;

    // bits that software may write, and bits that mirror live levels
    localparam pfr_flags_t SW_BITS = 8'hCF;
    localparam pfr_flags_t RO_BITS = 8'h30;
    localparam pfr_flags_t EE_BIT  = 8'h80;
    localparam pfr_flags_t NONE    = 8'h00;

endpackage

// *** logic/pfr_reg_if.sv ***
`timescale 1ns/100ps
interface pfr_reg_if #(
    parameter int AW = 8
);
    logic                wr;
    logic                rd;
    logic [AW-1:0]       addr;
    pfr_pkg::pfr_flags_t wdata;
    pfr_pkg::pfr_flags_t rdata;
    logic                hit;

    modport bus
    (
        output wr,
        output rd,
        output addr,
        output wdata,
        input  rdata,
        input  hit
    );

    modport core
    (
        input  wr,
        input  rd,
        input  addr,
        input  wdata,
        output rdata,
        output hit
    );
endinterface

// *** logic/pfr_flag_cell.sv ***
`timescale 1ns/100ps
module pfr_flag_cell #(
    parameter int          W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // set and clear strobes, set wins
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // stored flags
    output logic      [W-1:0] q
);
    initial
    begin
        if (W < 1)
            $error("pfr_flag_cell: W must be at least 1");
    end

    // a set in the same cycle as a clear is kept
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            q <= RST;
        else
            q <= (q & ~clr) | set;
    end
endmodule

// *** logic/pfr_apb_slave.sv ***
`timescale 1ns/100ps
module pfr_apb_slave #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // apb
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // register side
    pfr_reg_if.bus             rif
);
    logic setup;
    logic miss_q;

    initial
    begin
        if (AW < 5)
            $error("pfr_apb_slave: AW too small for the register map");
    end

    // zero wait states: every access phase completes at once
    assign setup     = psel & ~penable;
    assign pready    = 1'b1;
    assign rif.wr    = psel & penable & pwrite;
    assign rif.rd    = setup & ~pwrite;
    assign rif.addr  = paddr;
    assign rif.wdata = pwdata[pfr_pkg::FLAG_W-1:0];
    assign pslverr   = psel & penable & miss_q;

    // read data is caught at the setup edge so that it comes from a flop
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            prdata <= 32'h0000_0000;
            miss_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rif.rdata};
            miss_q <= ~rif.hit;
        end
    end
endmodule

// *** logic/pfr_top.sv ***
`timescale 1ns/100ps
// How it works
// - a source event sets its request flag, which then stays set until cleared.
// - no enable bit, per source or global, takes part in setting a flag.
// - the flag register answers at byte address 0x0C; its stored bits are zero after reset, bits 5 and 4 show the serial levels.
// - bit 7 sets when an eeprom write ends and reads zero while a write runs.
// - bit 6 sets when a conversion ends and only a software write of zero clears it.
module pfr_top #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // apb
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // eeprom write status
    input  wire logic          ee_write_busy,
    input  wire logic          ee_write_done,
    // converter
    input  wire logic          conv_done,
    // serial port levels
    input  wire logic          rx_full,
    input  wire logic          tx_empty,
    // other event pulses
    input  wire logic          sync_serial_done,
    input  wire logic          capcomp_event,
    input  wire logic          timer_two_match,
    input  wire logic          timer_one_overflow,
    // flag view and interrupt
    output logic      [7:0]    peripheral_request_flags_one,
    output logic               irq
);
    pfr_reg_if #(.AW(AW)) rif ();

    pfr_pkg::pfr_flags_t ev_set;
    pfr_pkg::pfr_flags_t pend_ev;
    pfr_pkg::pfr_flags_t flag_set;
    pfr_pkg::pfr_flags_t flag_clr;
    pfr_pkg::pfr_flags_t flag_q;
    pfr_pkg::pfr_flags_t flags_rd;
    pfr_pkg::pfr_flags_t pend_clr;
    pfr_pkg::pfr_flags_t pend_q;
    pfr_pkg::pfr_flags_t mask_q;
    logic                wr_flags;
    logic                wr_mask;
    logic                wr_pend;
    logic                rx_full_q;
    logic                tx_empty_q;

    initial
    begin
        if (AW < 5)
            $error("pfr_top: AW too small for the register map");
    end

    pfr_apb_slave #(.AW(AW)) u_bus (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rif     (rif.bus)
    );

    // address decode
    assign wr_flags = rif.wr && (rif.addr == AW'(pfr_pkg::FLAGS_OFS));
    assign wr_mask  = rif.wr && (rif.addr == AW'(pfr_pkg::MASK_OFS));
    assign wr_pend  = rif.wr && (rif.addr == AW'(pfr_pkg::PEND_OFS));

    always_comb
    begin
        rif.hit   = 1'b1;
        rif.rdata = pfr_pkg::NONE;
        if (rif.addr == AW'(pfr_pkg::FLAGS_OFS))
            rif.rdata = flags_rd;
        else if (rif.addr == AW'(pfr_pkg::MASK_OFS))
            rif.rdata = mask_q;
        else if (rif.addr == AW'(pfr_pkg::PEND_OFS))
            rif.rdata = pend_q;
        else
            rif.hit = 1'b0;
    end

    // source events; no enable of any kind is looked at here
    always_comb
    begin
        ev_set                    = pfr_pkg::NONE;
        ev_set[pfr_pkg::BIT_EE]   = ee_write_done;
        ev_set[pfr_pkg::BIT_CONV] = conv_done;
        ev_set[pfr_pkg::BIT_SSP]  = sync_serial_done;
        ev_set[pfr_pkg::BIT_CCP]  = capcomp_event;
        ev_set[pfr_pkg::BIT_T2]   = timer_two_match;
        ev_set[pfr_pkg::BIT_T1]   = timer_one_overflow;
    end

    // software may write ones or zeros to the writable bits; events still win
    always_comb
    begin
        flag_set = ev_set;
        flag_clr = pfr_pkg::RO_BITS;
        if (wr_flags)
        begin
            flag_set = flag_set | (rif.wdata & pfr_pkg::SW_BITS);
            flag_clr = flag_clr | (~rif.wdata & pfr_pkg::SW_BITS);
        end
        // a running write holds bit 7 at zero against software; only its own end sets it
        if (ee_write_busy)
        begin
            flag_set = (flag_set & ~pfr_pkg::EE_BIT) | ev_set;
            flag_clr = flag_clr | pfr_pkg::EE_BIT;
        end
    end

    pfr_flag_cell #(
        .W   (pfr_pkg::FLAG_W),
        .RST (pfr_pkg::FLAGS_RST)
    ) u_flags (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (flag_set),
        .clr     (flag_clr),
        .q       (flag_q)
    );

    // serial bits are live levels, so writes cannot disturb them
    always_comb
    begin
        flags_rd                  = flag_q & pfr_pkg::SW_BITS;
        flags_rd[pfr_pkg::BIT_RX] = rx_full;
        flags_rd[pfr_pkg::BIT_TX] = tx_empty;
    end

    assign peripheral_request_flags_one = flags_rd;

    // level edges turn the serial levels into interrupt events
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            rx_full_q  <= 1'b0;
            // empty is the idle level of the transmitter, so reset must not look like an edge
            tx_empty_q <= 1'b1;
        end
        else
        begin
            rx_full_q  <= rx_full;
            tx_empty_q <= tx_empty;
        end
    end

    always_comb
    begin
        pend_ev                  = ev_set;
        pend_ev[pfr_pkg::BIT_RX] = rx_full & ~rx_full_q;
        pend_ev[pfr_pkg::BIT_TX] = tx_empty & ~tx_empty_q;
    end

    // pending bits clear by writing one; an event in that cycle survives
    assign pend_clr = wr_pend ? rif.wdata : pfr_pkg::NONE;

    pfr_flag_cell #(
        .W   (pfr_pkg::FLAG_W),
        .RST (pfr_pkg::PEND_RST)
    ) u_pend (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (pend_ev),
        .clr     (pend_clr),
        .q       (pend_q)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            mask_q <= pfr_pkg::MASK_RST;
        else if (wr_mask)
            mask_q <= rif.wdata;
    end

    assign irq = |(pend_q & mask_q);

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_rd_flags_setup;
        rif.rd && (rif.addr == AW'(pfr_pkg::FLAGS_OFS));
    endsequence

    sequence s_tx_rise;
        !tx_empty ##1 tx_empty;
    endsequence

    sequence s_rx_rise;
        !rx_full ##1 rx_full;
    endsequence

    sequence s_bad_access;
        (psel && !penable && !rif.hit) ##1 (psel && penable);
    endsequence

    property p_flag_hold;
        (!wr_flags && !ee_write_busy) |=> ((flag_q & $past(flag_q)) == $past(flag_q));
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("a request flag dropped without a clear");

    property p_t1_sets;
        timer_one_overflow |=> flag_q[pfr_pkg::BIT_T1];
    endproperty
    a_t1_sets: assert property (p_t1_sets)
        else $error("timer one overflow did not set its flag");

    property p_reset_zero;
        (rstn && $past(!rstn)) |-> (flag_q == pfr_pkg::FLAGS_RST);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("flags not zero after reset");

    property p_read_flags;
        s_rd_flags_setup |=> (prdata == {24'h00_0000, $past(flags_rd)});
    endproperty
    a_read_flags: assert property (p_read_flags)
        else $error("flag register read returned the wrong value");

    property p_ee_busy_zero;
        (ee_write_busy && !ee_write_done) |=> !flag_q[pfr_pkg::BIT_EE];
    endproperty
    a_ee_busy_zero: assert property (p_ee_busy_zero)
        else $error("eeprom flag set while a write runs");

    property p_ee_done;
        ee_write_done |=> flag_q[pfr_pkg::BIT_EE] && pend_q[pfr_pkg::BIT_EE];
    endproperty
    a_ee_done: assert property (p_ee_done)
        else $error("eeprom write end did not set its flag");

    property p_conv_only_sw;
        ($fell(flag_q[pfr_pkg::BIT_CONV]) && $past(rstn))
            |-> $past(wr_flags && !rif.wdata[pfr_pkg::BIT_CONV]);
    endproperty
    a_conv_only_sw: assert property (p_conv_only_sw)
        else $error("conversion flag cleared by hardware");

    property p_serial_ro;
        wr_flags |=> ((flag_q & pfr_pkg::RO_BITS) == pfr_pkg::NONE)
            && (peripheral_request_flags_one[pfr_pkg::BIT_RX] == rx_full);
    endproperty
    a_serial_ro: assert property (p_serial_ro)
        else $error("serial receive bit changed by a write");

    property p_tx_pend;
        s_tx_rise |=> pend_q[pfr_pkg::BIT_TX];
    endproperty
    a_tx_pend: assert property (p_tx_pend)
        else $error("transmit empty edge did not reach pending");

    property p_ssp_sets;
        sync_serial_done |=> flag_q[pfr_pkg::BIT_SSP]
            ##1 (flag_q[pfr_pkg::BIT_SSP] || $past(wr_flags));
    endproperty
    a_ssp_sets: assert property (p_ssp_sets)
        else $error("serial port done flag not held");

    property p_conv_sets;
        conv_done |=> flag_q[pfr_pkg::BIT_CONV] && pend_q[pfr_pkg::BIT_CONV];
    endproperty
    a_conv_sets: assert property (p_conv_sets)
        else $error("conversion end did not set its flag");

    property p_sw_clear;
        (wr_flags && !rif.wdata[pfr_pkg::BIT_T2] && !timer_two_match) |=> !flag_q[pfr_pkg::BIT_T2];
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software clear of the timer two flag was lost");

    property p_reset_all;
        (rstn && $past(!rstn)) |-> (pend_q == pfr_pkg::PEND_RST) && (mask_q == pfr_pkg::MASK_RST) && !irq;
    endproperty
    a_reset_all: assert property (p_reset_all)
        else $error("pending or mask not zero after reset");

    property p_rx_pend;
        s_rx_rise |=> pend_q[pfr_pkg::BIT_RX];
    endproperty
    a_rx_pend: assert property (p_rx_pend)
        else $error("receive full edge did not reach pending");

    property p_ccp_sets;
        capcomp_event |=> flag_q[pfr_pkg::BIT_CCP] && pend_q[pfr_pkg::BIT_CCP];
    endproperty
    a_ccp_sets: assert property (p_ccp_sets)
        else $error("capture compare event did not set its flag");

    property p_t2_sets;
        timer_two_match |=> flag_q[pfr_pkg::BIT_T2];
    endproperty
    a_t2_sets: assert property (p_t2_sets)
        else $error("timer two match did not set its flag");

    property p_bad_addr;
        s_bad_access |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped access did not raise the error response");
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq;
    logic        ee_write_busy = 1'b0, ee_write_done = 1'b0, conv_done = 1'b0;
    logic        rx_full = 1'b0, tx_empty = 1'b0, sync_serial_done = 1'b0;
    logic        capcomp_event = 1'b0, timer_two_match = 1'b0, timer_one_overflow = 1'b0;
    logic [7:0]  view;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0, checks_done = 0, cyc = 0;

    pfr_top dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_write_busy(ee_write_busy), .ee_write_done(ee_write_done),
        .conv_done(conv_done), .rx_full(rx_full), .tx_empty(tx_empty),
        .sync_serial_done(sync_serial_done), .capcomp_event(capcomp_event),
        .timer_two_match(timer_two_match), .timer_one_overflow(timer_one_overflow),
        .peripheral_request_flags_one(view), .irq(irq));

    always #5 clk_sys = ~clk_sys;

    // ceiling well above the roughly 125 cycles the scenarios need
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // leading edge keeps a release and the next setup out of one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // only the bench timeout ends a wait on a slave that never answers
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys);
        case (b)
            0: timer_one_overflow <= 1'b1;
            1: timer_two_match <= 1'b1;
            2: capcomp_event <= 1'b1;
            3: sync_serial_done <= 1'b1;
            6: conv_done <= 1'b1;
            default: ee_write_done <= 1'b1;
        endcase
        @(posedge clk_sys);
        {timer_one_overflow, timer_two_match, capcomp_event} <= 3'h0;
        {sync_serial_done, conv_done, ee_write_done} <= 3'h0;
    endtask

    task automatic t_reset();
        settle(1);
        chk({23'h0, view, irq}, 32'h0);
        rd_chk(pfr_pkg::FLAGS_OFS, 32'h0);
        rd_chk(pfr_pkg::MASK_OFS, 32'h0);
        rd_chk(pfr_pkg::PEND_OFS, 32'h0);
    endtask

    task automatic t_events();
        int          bits[6] = '{0, 1, 2, 3, 6, 7};
        logic [7:0]  exp;
        exp = 8'h00;
        foreach (bits[i])
        begin
            pulse(bits[i]);
            exp[bits[i]] = 1'b1;
            settle(4);
            chk(view, exp);
            chk(irq, 1'b0);
        end
        rd_chk(pfr_pkg::FLAGS_OFS, {24'h0, exp});
        rd_chk(pfr_pkg::PEND_OFS, {24'h0, exp});
        apb(1'b1, pfr_pkg::PEND_OFS, 32'hFF);
        apb(1'b1, pfr_pkg::MASK_OFS, 32'hFF);
        settle(1);
        chk(irq, 1'b0);
        pulse(0);
        settle(1);
        chk(irq, 1'b1);
        apb(1'b1, pfr_pkg::PEND_OFS, 32'h01);
        settle(1);
        chk(irq, 1'b0);
        chk(view, exp);
    endtask

    task automatic t_clear();
        apb(1'b1, pfr_pkg::FLAGS_OFS, 32'h80);
        settle(1);
        chk(view, 8'h80);
        @(posedge clk_sys);
        ee_write_busy <= 1'b1;
        settle(2);
        chk(view, 8'h00);
        apb(1'b1, pfr_pkg::FLAGS_OFS, 32'h80);
        settle(1);
        chk(view, 8'h00);
        @(posedge clk_sys);
        ee_write_busy <= 1'b0;
        settle(2);
        chk(view, 8'h00);
    endtask

    task automatic t_serial();
        @(posedge clk_sys);
        rx_full <= 1'b1;
        tx_empty <= 1'b1;
        settle(3);
        chk(view, 8'h30);
        apb(1'b1, pfr_pkg::FLAGS_OFS, 32'h00);
        settle(1);
        chk(view, 8'h30);
        rd_chk(pfr_pkg::PEND_OFS, 32'h30);
        chk(irq, 1'b1);
        apb(1'b1, pfr_pkg::PEND_OFS, 32'h30);
        @(posedge clk_sys);
        rx_full <= 1'b0;
        tx_empty <= 1'b0;
        settle(2);
        chk({view, irq}, 9'h0);
    endtask

    task automatic t_unmapped();
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h20, 32'hFF);
        chk(err, 1'b1);
        rd_chk(pfr_pkg::FLAGS_OFS, 32'h0);
    endtask

    // reset in mid-run with a flag, a pending bit and the mask all set
    task automatic t_midrun_reset();
        pulse(6);
        settle(1);
        chk(irq, 1'b1);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_events();
        t_clear();
        t_serial();
        t_unmapped();
        t_midrun_reset();
        finish_test();
    end
endmodule
